// ==== ebcid_defines.svh ====
/*
  Constants for the instruction decode and timing block: word width,
  field positions, opcode patterns and cycle counts.
  Assumes it is included by bare name by every file that needs it.
*/
`ifndef EBCID_DEFINES_SVH
`define EBCID_DEFINES_SVH

// ============================================================
// word and timing
`define EBCID_IW        14
`define EBCID_QUAD      4
`define EBCID_PH_FIRST  2'h0
`define EBCID_PH_READ   2'h1
`define EBCID_PH_MOD    2'h2
`define EBCID_PH_LAST   2'h3
`define EBCID_CYC_BASE  2'h1
`define EBCID_CYC_STEP  2'h1
`define EBCID_CYC_ZERO  2'h0

// ============================================================
// field positions
`define EBCID_OP_MSB    13
`define EBCID_BOP_LSB   8
`define EBCID_TOP_LSB   10
`define EBCID_D_POS     7
`define EBCID_F_MSB     6
`define EBCID_B_MSB     9
`define EBCID_B_LSB     7
`define EBCID_OFS_N_POS 6
`define EBCID_INC_N_POS 2

// ============================================================
// opcode patterns
`define EBCID_OP_CTRL0     7'h00
`define EBCID_OP_SUB_CALL  3'h4
`define EBCID_OP_ABS_JUMP  3'h5
`define EBCID_OP_REL_JUMP  5'h19
`define EBCID_OP_EXIT_LIT  6'h34
`define EBCID_OP_SUB_RET   14'h0008
`define EBCID_OP_INT_EXIT  14'h0009
`define EBCID_OP_SUB_ACC   14'h000A
`define EBCID_OP_ACC_JUMP  14'h000B
`define EBCID_OP_DEC_SKIP  6'h0B
`define EBCID_OP_INC_SKIP  6'h0F
`define EBCID_OP_CLEAR     6'h01
`define EBCID_OP_ADD_CY    6'h3D
`define EBCID_OP_SUB_BW    6'h3B
`define EBCID_OP_SH_LEFT   6'h35
`define EBCID_OP_SH_RIGHT  6'h36
`define EBCID_OP_SH_ARITH  6'h37
`define EBCID_OP_PTR_INC   10'h001
`define EBCID_OP_PTR_OFS   7'h62
`define EBCID_OP_PTR_IDX   7'h7E
`define EBCID_IND_BASE     6'h00

`endif

// ==== ebcid_pkg.sv ====
/*
  Types shared by the decode block: format group, sequencer state and
  the decoded instruction record.
  Assumes nothing of its surroundings.
*/
package ebcid_pkg;

  typedef enum logic [1:0] {
    EBCID_FMT_BYTE,
    EBCID_FMT_BIT,
    EBCID_FMT_LIT
  } ebcid_fmt_t;

  typedef enum logic [1:0] {
    EBCID_ST_NOP,
    EBCID_ST_IND,
    EBCID_ST_EXEC
  } ebcid_st_t;

  typedef struct packed {
    ebcid_fmt_t  fmt;
    logic [5:0]  opcode;
    logic        dest;
    logic [6:0]  faddr;
    logic [2:0]  bitpos;
    logic [7:0]  k8;
    logic [10:0] k11;
    logic [8:0]  k9;
    logic [6:0]  k7;
    logic [4:0]  k5;
    logic [5:0]  k6;
    logic        ptr_n;
    logic [1:0]  ptr_mode;
    logic        file_op;
    logic        wr_file;
    logic        wr_acc;
    logic        jump;
    logic        test_skip;
    logic        ind;
    logic        ind_n;
  } ebcid_dec_t;

endpackage

// ==== ebcid_quad_div.sv ====
/*
  Divides the oscillator clock into the four phases of one
  instruction cycle and flags the last phase.
  Assumes one free-running clock and an asynchronous low reset.
*/
`timescale 1ns/10ps
`include "ebcid_defines.svh"

module ebcid_quad_div (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // phase
  output logic [1:0]      o_phase,
  output logic            o_q_end
);

  logic [1:0] phase_r;

  // ============================================================
  // phase counter
  // a two-bit counter wraps after exactly four clocks
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= `EBCID_PH_FIRST;
    end else begin
      phase_r <= phase_r + `EBCID_CYC_STEP;
    end
  end

  assign o_phase = phase_r;
  assign o_q_end = (phase_r == `EBCID_PH_LAST);

endmodule // ebcid_quad_div

// ==== ebcid_field_dec.sv ====
/*
  Pure combinational decode of one instruction word into format,
  operand fields and control flags.
  Assumes the word is stable while it is sampled.
*/
`timescale 1ns/10ps
`include "ebcid_defines.svh"

module ebcid_field_dec
  import ebcid_pkg::*;
(
  // word
  input  wire logic [13:0] i_word,
  // decoded record
  output ebcid_dec_t       o_dec
);

  logic [5:0] op6;
  logic       ctrl0, hi_byte, is_byte, is_bit, bit_test, clr_acc;
  logic       ptr_inc, ptr_ofs, jmp, skp, fop;

  // ============================================================
  // format groups
  // don't-care bits ignored
  // only fixed opcode bits are compared; don't-care bits never reach
  assign op6      = i_word[`EBCID_OP_MSB:`EBCID_BOP_LSB];
  assign ctrl0    = (i_word[13:7] == `EBCID_OP_CTRL0);
  assign hi_byte  = (op6 == `EBCID_OP_ADD_CY)  | (op6 == `EBCID_OP_SUB_BW)
                  | (op6 == `EBCID_OP_SH_LEFT) | (op6 == `EBCID_OP_SH_RIGHT)
                  | (op6 == `EBCID_OP_SH_ARITH);
  assign is_byte  = ((i_word[13:12] == 2'h0) & ~ctrl0) | hi_byte;
  assign is_bit   = (i_word[13:12] == 2'h1);
  assign bit_test = is_bit & i_word[11];
  // clear of the accumulator has no file operand
  assign clr_acc  = (op6 == `EBCID_OP_CLEAR) & ~i_word[`EBCID_D_POS];
  assign ptr_inc  = (i_word[13:4] == `EBCID_OP_PTR_INC);
  assign ptr_ofs  = (i_word[13:7] == `EBCID_OP_PTR_OFS)
                  | (i_word[13:7] == `EBCID_OP_PTR_IDX);

  // ============================================================
  // flow control
  // flow changes
  assign jmp = (i_word[13:11] == `EBCID_OP_SUB_CALL)
             | (i_word[13:11] == `EBCID_OP_ABS_JUMP)
             | (i_word[13:9]  == `EBCID_OP_REL_JUMP)
             | (op6 == `EBCID_OP_EXIT_LIT)
             | (i_word == `EBCID_OP_SUB_RET)
             | (i_word == `EBCID_OP_INT_EXIT)
             | (i_word == `EBCID_OP_SUB_ACC)
             | (i_word == `EBCID_OP_ACC_JUMP);
  assign skp = bit_test | (op6 == `EBCID_OP_DEC_SKIP)
             | (op6 == `EBCID_OP_INC_SKIP);
  assign fop = (is_byte & ~clr_acc) | is_bit;

  // ============================================================
  // record
  assign o_dec.fmt      = is_byte ? EBCID_FMT_BYTE :
                          is_bit  ? EBCID_FMT_BIT  : EBCID_FMT_LIT;
  assign o_dec.opcode   = is_bit ? {2'h0, i_word[13:10]} : op6;
  assign o_dec.dest     = i_word[`EBCID_D_POS];
  assign o_dec.faddr    = i_word[`EBCID_F_MSB:0];
  assign o_dec.bitpos   = i_word[`EBCID_B_MSB:`EBCID_B_LSB];
  assign o_dec.k8       = i_word[7:0];
  assign o_dec.k11      = i_word[10:0];
  assign o_dec.k9       = i_word[8:0];
  assign o_dec.k7       = i_word[6:0];
  assign o_dec.k5       = i_word[4:0];
  assign o_dec.k6       = i_word[5:0];
  assign o_dec.ptr_n    = (ptr_inc & i_word[`EBCID_INC_N_POS])
                        | (ptr_ofs & i_word[`EBCID_OFS_N_POS]);
  assign o_dec.ptr_mode = ptr_inc ? i_word[1:0] : 2'h0;
  assign o_dec.file_op  = fop;
  assign o_dec.wr_file  = (is_byte & fop & i_word[`EBCID_D_POS])
                        | (is_bit & ~bit_test);
  assign o_dec.wr_acc   = is_byte & ~i_word[`EBCID_D_POS];
  assign o_dec.jump     = jmp;
  assign o_dec.test_skip = skp;
  assign o_dec.ind      = fop & (i_word[6:1] == `EBCID_IND_BASE);
  assign o_dec.ind_n    = i_word[0];

endmodule // ebcid_field_dec

// ==== ebcid_core.sv ====
/*
  Instruction decode and cycle sequencer of an 8-bit core: takes a
  fresh 14-bit word at the end of each fetch cycle, decodes it, and
  drives read, write and cycle-type strobes in the four phases.
  Assumes the word and the datapath skip result are valid on the
  clock edge that ends phase 3.
*/
// Summary of operation
// - one 14-bit word per instruction holds opcode and all operands
// - every word falls into byte, bit or literal-and-control group
// - instructions take one instruction cycle unless listed otherwise
// - both subroutine call forms take two instruction cycles
// - subroutine return, literal return and interrupt exit take two
// - jumps and taken skips take two instruction cycles
// - indirect access to program memory adds one cycle
// - one instruction cycle is four clocks
// - file operands are read before being modified and written back
// - destination bit 0 writes accumulator, 1 writes file register
// - file address is seven bits, 0x00 to 0x7F
// - bit group carries a three-bit bit position
// - literal width follows the format: 8, 11, 9, 7, 5 or 6 bits
// - a one-bit field chooses pointer 0 or pointer 1
// - a two-bit field chooses pre or post increment or decrement
// - don't-care bits never change the operation
// - the second cycle of a jump or taken skip is a no-operation
`timescale 1ns/10ps
`include "ebcid_defines.svh"

module ebcid_core
  import ebcid_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // fetch side
  input  wire logic [13:0] i_instr,
  // datapath side
  input  wire logic        i_skip_true,
  input  wire logic [1:0]  i_ptr_pgm,
  // timing
  output logic [1:0]       o_phase,
  output logic             o_take,
  output logic [1:0]       o_cycles,
  // decoded word
  output ebcid_dec_t       o_dec,
  // cycle type
  output logic             o_exec,
  output logic             o_ind_cyc,
  output logic             o_nop_cyc,
  // file and accumulator strobes
  output logic             o_rd_file,
  output logic             o_wr_file,
  output logic             o_wr_acc
);

  logic [1:0] phase_w;
  logic       q_end_w;
  ebcid_dec_t in_dec_w;
  ebcid_dec_t dec_r;
  ebcid_st_t  state_r, state_nxt;
  logic       redirect_w, fetch_w, in_ind_w, skip_hit_w;
  logic       take_r, ex_r, ind_r, nop_r;
  logic       rd_r, wf_r, wa_r;
  logic [1:0] cyc_r, cyc_nxt;
  logic       rd_nxt, wf_nxt, wa_nxt;

  // ============================================================
  // phase divider
  // four clocks per cycle
  ebcid_quad_div u_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_phase   (phase_w),
    .o_q_end   (q_end_w)
  );

  // ============================================================
  // word decode
  // whole word decoded at once
  ebcid_field_dec u_fld (
    .i_word (i_instr),
    .o_dec  (in_dec_w)
  );

  // ============================================================
  // sequencing terms
  // a true test turns the next cycle into a flush
  assign skip_hit_w = dec_r.test_skip & i_skip_true;
  // calls, returns and jumps always redirect
  assign redirect_w = dec_r.jump | skip_hit_w;
  assign fetch_w    = q_end_w & ((state_r == EBCID_ST_NOP)
                    | ((state_r == EBCID_ST_EXEC) & ~redirect_w));
  // pointer aimed at program memory costs a cycle
  assign in_ind_w   = in_dec_w.ind & i_ptr_pgm[in_dec_w.ind_n];

  // ============================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    if (q_end_w) begin
      case (state_r)
        EBCID_ST_NOP: begin
          state_nxt = in_ind_w ? EBCID_ST_IND : EBCID_ST_EXEC;
        end
        EBCID_ST_IND: begin
          state_nxt = EBCID_ST_EXEC;
        end
        EBCID_ST_EXEC: begin
          // the redirect cycle executes as a no-operation
          if (redirect_w) begin
            state_nxt = EBCID_ST_NOP;
          end else begin
            state_nxt = in_ind_w ? EBCID_ST_IND : EBCID_ST_EXEC;
          end
        end
        default: begin
          state_nxt = EBCID_ST_NOP;
        end
      endcase
    end
  end

  // ============================================================
  // cycle count of the current instruction
  always_comb begin
    cyc_nxt = cyc_r;
    if (fetch_w) begin
      // one cycle plus any listed extras
      cyc_nxt = `EBCID_CYC_BASE
              + (in_ind_w ? `EBCID_CYC_STEP : `EBCID_CYC_ZERO)
              + (in_dec_w.jump ? `EBCID_CYC_STEP : `EBCID_CYC_ZERO);
    end else if (q_end_w & (state_r == EBCID_ST_EXEC) & skip_hit_w) begin
      // skip taken adds the flush cycle
      cyc_nxt = cyc_r + `EBCID_CYC_STEP;
    end
  end

  // ============================================================
  // strobes, one phase ahead so the outputs are flops
  // read in phase 1 even for write-only operands
  assign rd_nxt = (state_r == EBCID_ST_EXEC) & (phase_w == `EBCID_PH_FIRST)
                & dec_r.file_op;
  // destination bit picks the write target in phase 3
  assign wf_nxt = (state_r == EBCID_ST_EXEC) & (phase_w == `EBCID_PH_MOD)
                & dec_r.wr_file;
  assign wa_nxt = (state_r == EBCID_ST_EXEC) & (phase_w == `EBCID_PH_MOD)
                & dec_r.wr_acc;

  // ============================================================
  // state and decoded word
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= EBCID_ST_NOP;
      dec_r   <= '0;
      cyc_r   <= `EBCID_CYC_ZERO;
    end else begin
      state_r <= state_nxt;
      cyc_r   <= cyc_nxt;
      // record latched only on a fetch
      if (fetch_w) begin
        dec_r <= in_dec_w;
      end
    end
  end

  // ============================================================
  // registered outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      take_r <= 1'b0;
      ex_r   <= 1'b0;
      ind_r  <= 1'b0;
      nop_r  <= 1'b1;
      rd_r   <= 1'b0;
      wf_r   <= 1'b0;
      wa_r   <= 1'b0;
    end else begin
      take_r <= fetch_w;
      ex_r   <= (state_nxt == EBCID_ST_EXEC);
      ind_r  <= (state_nxt == EBCID_ST_IND);
      nop_r  <= (state_nxt == EBCID_ST_NOP);
      rd_r   <= rd_nxt;
      wf_r   <= wf_nxt;
      wa_r   <= wa_nxt;
    end
  end

  // fields leave as extracted; wide record costs flops but no muxing
  // field set
  assign o_dec     = dec_r;
  assign o_phase   = phase_w;
  assign o_take    = take_r;
  assign o_cycles  = cyc_r;
  assign o_exec    = ex_r;
  assign o_ind_cyc = ind_r;
  assign o_nop_cyc = nop_r;
  assign o_rd_file = rd_r;
  assign o_wr_file = wf_r;
  assign o_wr_acc  = wa_r;

  // ============================================================
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_quad_order: assert property (
    o_phase == 2'h3 |=> o_phase == 2'h0 ##1 o_phase == 2'h1
      ##1 o_phase == 2'h2 ##1 o_phase == 2'h3)
    else $error("phase order broken");

  a_take_phase: assert property (
    o_take |-> o_phase == 2'h0 && !o_nop_cyc)
    else $error("word taken off phase 0");

  a_one_cycle: assert property (
    o_take && !o_ind_cyc && !o_dec.jump && !o_dec.test_skip
      |=> (!o_take)[*3] ##1 o_take)
    else $error("plain instruction not one cycle");

  a_jump_two: assert property (
    o_take && !o_ind_cyc && o_dec.jump
      |-> o_cycles == 2'h2 ##1 (!o_take)[*7] ##1 o_take)
    else $error("flow change not two cycles");

  a_ind_extra: assert property (
    o_take && o_ind_cyc |-> o_ind_cyc[*4] ##1 o_exec[*4])
    else $error("indirect extra cycle missing");

  a_skip_flush: assert property (
    o_exec && o_phase == 2'h3 && o_dec.test_skip && i_skip_true
      |=> o_nop_cyc[*4] ##1 o_take)
    else $error("taken skip not flushed");

  a_nop_quiet: assert property (
    o_nop_cyc |-> !o_rd_file && !o_wr_file && !o_wr_acc)
    else $error("strobe during no-operation");

  a_rmw_order: assert property (
    o_wr_file |-> $past(o_rd_file, 2) && o_phase == 2'h3)
    else $error("write without prior read");

  a_acc_dest: assert property (
    o_wr_acc |-> !o_dec.dest && o_dec.fmt == EBCID_FMT_BYTE)
    else $error("accumulator write with d set");

  a_file_dest: assert property (
    o_wr_file && o_dec.fmt == EBCID_FMT_BYTE |-> o_dec.dest)
    else $error("file write with d clear");

  a_addr_field: assert property (
    o_take |-> o_dec.faddr == $past(i_instr[6:0])
      && o_dec.dest == $past(i_instr[7]))
    else $error("file address field wrong");

  a_bit_field: assert property (
    o_take && o_dec.fmt == EBCID_FMT_BIT
      |-> o_dec.bitpos == $past(i_instr[9:7]))
    else $error("bit position field wrong");

  a_ret_lit: assert property (
    o_take && !o_ind_cyc && o_dec.fmt == EBCID_FMT_LIT
      && o_dec.opcode == `EBCID_OP_EXIT_LIT |-> o_cycles == 2'h2)
    else $error("literal return not two cycles");

  a_ind_quiet: assert property (
    o_ind_cyc |-> !o_rd_file && !o_wr_file && !o_wr_acc)
    else $error("strobe during indirect cycle");

  a_rd_phase: assert property (
    o_rd_file |-> o_phase == 2'h1 && o_exec && o_dec.file_op)
    else $error("file read off phase 1");

  a_acc_phase: assert property (
    o_wr_acc |-> o_phase == 2'h3 && o_exec)
    else $error("accumulator write off phase 3");

  a_skip_count: assert property (
    o_exec && o_phase == 2'h3 && o_dec.test_skip && i_skip_true
      |=> o_cycles == 2'($past(o_cycles) + 2'h1))
    else $error("taken skip not counted");

  a_clr_acc: assert property (
    o_take && o_dec.fmt == EBCID_FMT_BYTE && !o_dec.dest
      && o_dec.opcode == `EBCID_OP_CLEAR |-> !o_dec.file_op && o_dec.wr_acc)
    else $error("accumulator clear decoded wrong");

  a_ptr_step: assert property (
    o_take && $past(i_instr[13:4]) == `EBCID_OP_PTR_INC
      |-> o_dec.ptr_mode == $past(i_instr[1:0])
      && o_dec.ptr_n == $past(i_instr[2]))
    else $error("pointer step fields wrong");

  a_ptr_ofs: assert property (
    o_take && $past(i_instr[13:7]) == `EBCID_OP_PTR_OFS
      |-> o_dec.ptr_n == $past(i_instr[6])
      && o_dec.k6 == $past(i_instr[5:0]))
    else $error("pointer offset fields wrong");

  a_lit_field: assert property (
    o_take |-> o_dec.k8 == $past(i_instr[7:0])
      && o_dec.k11 == $past(i_instr[10:0]) && o_dec.k9 == $past(i_instr[8:0]))
    else $error("literal field wrong");

endmodule // ebcid_core

// ==== ebcid_prog_model.sv ====
/*
  Program memory and datapath stand-in for the decode block: serves
  one word per instruction, the skip result and the pointer flags.
  Assumes the bench fills the arrays before the first falling edge.
*/
`timescale 1ns/10ps

module ebcid_prog_model (
  // clock and take pulse
  input  wire logic   i_sys_clk,
  input  wire logic   i_take,
  // fetch and datapath side
  output logic [13:0] o_instr,
  output logic        o_skip_true,
  output logic [1:0]  o_ptr_pgm
);
  // ==========================================================
  // storage
  logic [13:0] prog [0:255];
  logic        skp  [0:255];
  logic [1:0]  pgm  [0:255];
  int          pc;
  int          nxt;

  initial begin
    pc          = 0;
    o_instr     = 14'h0000;
    o_skip_true = 1'b0;
    o_ptr_pgm   = 2'h0;
  end

  // ==========================================================
  // fetch and skip result
  // no branch targets: after a redirect the next listed word follows
  // whole word served
  always @(negedge i_sys_clk) begin
    nxt = i_take ? pc + 1 : pc;
    pc          <= nxt;
    o_instr     <= prog[nxt];
    o_ptr_pgm   <= pgm[nxt];
    o_skip_true <= (nxt > 0) ? skp[nxt-1] : 1'b0;
  end
endmodule // ebcid_prog_model

// ==== tb_eight_bit_core_instr_decode.sv ====
/*
  Self-checking bench for the decode and timing block: corner words
  then random words, each checked for fields, cycles and strobes.
  Assumes the program model in its own file.
*/
`timescale 1ns/10ps

module tb_eight_bit_core_instr_decode
  import ebcid_pkg::*;
;
  // ==========================================================
  // signals
  logic        i_sys_clk;
  logic        i_rst_n;
  logic [13:0] i_instr;
  logic        i_skip_true;
  logic [1:0]  i_ptr_pgm;
  logic [1:0]  o_phase;
  logic        o_take;
  logic [1:0]  o_cycles;
  ebcid_dec_t  o_dec;
  logic        o_exec;
  logic        o_ind_cyc;
  logic        o_nop_cyc;
  logic        o_rd_file;
  logic        o_wr_file;
  logic        o_wr_acc;
  int          error_cnt;
  int          checks;
  int          seed;
  int          n;
  int          kd;
  int          kind [0:255];
  int          clk_n, ex_n, in_n, np_n, rd_n, wf_n, wa_n;
  int          e_cyc;
  logic        e_fo, e_wchk, e_wf, e_wa, e_ind, e_nop;
  logic [2:0]  e_flg, got_flg;
  logic [1:0]  last_cyc;
  logic [13:0] w;
  ebcid_fmt_t  ef;
  logic [5:0]  bops [0:18] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
    6'h35, 6'h36, 6'h37, 6'h3B, 6'h3D};
  logic [5:0]  lops [0:6] = '{6'h30, 6'h38, 6'h39, 6'h3A, 6'h3C,
    6'h3E, 6'h34};
  logic [13:0] ctl [0:4] = '{14'h0000, 14'h0008, 14'h0009, 14'h000A,
    14'h000B};

  ebcid_core u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
    .i_skip_true(i_skip_true), .i_ptr_pgm(i_ptr_pgm),
    .o_phase(o_phase), .o_take(o_take), .o_cycles(o_cycles),
    .o_dec(o_dec), .o_exec(o_exec), .o_ind_cyc(o_ind_cyc),
    .o_nop_cyc(o_nop_cyc), .o_rd_file(o_rd_file),
    .o_wr_file(o_wr_file), .o_wr_acc(o_wr_acc)
  );

  ebcid_prog_model u_mem (
    .i_sys_clk(i_sys_clk), .i_take(o_take), .o_instr(i_instr),
    .o_skip_true(i_skip_true), .o_ptr_pgm(i_ptr_pgm)
  );

  assign got_flg = {o_dec.file_op, o_dec.jump, o_dec.test_skip};

  // ==========================================================
  // helpers
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t ns %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // kinds: 0 byte, 1 bit, 2 k8, 3 k11, 4 k9, 5 k7, 6 k5, 7 k6,
  // 8 pointer step, 9 control, 10 clear accumulator
  function automatic void calc(input int k, input logic [13:0] x,
                               input logic sk, input logic [1:0] pg);
    logic jmp;
    logic sop;
    jmp = k inside {3, 4} || (k == 9 && x != 14'h0000) ||
          (k == 2 && x[13:8] == 6'h34);
    sop = (k == 0 && !x[13] && x[11:8] inside {4'hB, 4'hF}) ||
          (k == 1 && x[11]);
    e_fo   = k < 2;
    e_wchk = k == 0 || k == 10;
    e_wf   = k == 0 && x[7];
    e_wa   = (k == 0 && !x[7]) || k == 10;
    e_ind  = e_fo && x[6:1] == 6'h00 && pg[x[0]];
    e_nop  = jmp || (sop && sk);
    e_cyc  = 1 + int'(e_ind) + int'(e_nop);
    e_flg  = {e_fo, jmp, sop};
  endfunction

  task automatic put(input int i, input int k, input logic [13:0] x,
                     input logic s, input logic [1:0] p);
    kind[i]        = k;
    u_mem.prog[i]  = x;
    u_mem.skp[i]   = s;
    u_mem.pgm[i]   = p;
  endtask

  task automatic gen(input int i);
    logic [13:0] r;
    int          k;
    r = 14'($random(seed));
    k = ($random(seed) & 32'h7FFF) % 11;
    case (k)
      0: r[13:8] = bops[r[12:8] % 19];
      1: r[13:12] = 2'h1;
      2: r[13:8] = lops[r[10:8] % 7];
      3: r[13:12] = 2'h2;
      4: r[13:9] = 5'h19;
      5: r[13:7] = 7'h63;
      6: r[13:5] = 9'h001;
      7: r[13:7] = 7'h62;
      8: r[13:4] = 10'h001;
      9: r = ctl[r[2:0] % 5];
      default: r = {12'h040, r[1:0]};
    endcase
    // steer often onto the pointer registers, else indirect is rare
    if (k < 2 && ($random(seed) & 1)) r[6:1] = 6'h00;
    put(i, k, r, 1'($random(seed)), 2'($random(seed)));
  endtask

  // ==========================================================
  // monitor
  always @(negedge i_sys_clk) begin
    if (!i_rst_n) begin
      cmp(16'({o_nop_cyc, o_take}), 16'h0002, "reset state");
    end else begin
      if (o_take) begin
        if (n > 0) begin
          cmp(16'(clk_n), 16'(4 * e_cyc), "spacing");
          cmp(16'(last_cyc), 16'(e_cyc), "cycles");
          cmp(16'(ex_n), 16'h0004, "exec clocks");
          cmp(16'(in_n), 16'(4 * e_ind), "ind clocks");
          cmp(16'(np_n), 16'(4 * e_nop), "nop clocks");
          cmp(16'(rd_n), 16'(e_fo), "reads");
          if (e_wchk) cmp(16'(wf_n * 2 + wa_n), 16'({e_wf, e_wa}), "wr");
        end
        w  = u_mem.prog[n];
        kd = kind[n];
        calc(kd, w, u_mem.skp[n], u_mem.pgm[n]);
        ef = kd == 0 ? EBCID_FMT_BYTE : kd == 1 ? EBCID_FMT_BIT :
             EBCID_FMT_LIT;
        cmp(16'(o_phase), 16'h0000, "take phase");
        if (kd < 10) cmp(16'(o_dec.fmt), 16'(ef), "format");
        cmp(16'(got_flg), 16'(e_flg), "flags");
        case (kd)
          0: begin
            cmp(16'(o_dec.opcode), 16'(w[13:8]), "byte op");
            cmp(16'(o_dec.dest), 16'(w[7]), "dest");
          end
          1: begin
            cmp(16'(o_dec.opcode), 16'(w[13:10]), "bit op");
            cmp(16'(o_dec.bitpos), 16'(w[9:7]), "bitpos");
          end
          2: cmp(16'(o_dec.k8), 16'(w[7:0]), "k8");
          3: cmp(16'(o_dec.k11), 16'(w[10:0]), "k11");
          4: cmp(16'(o_dec.k9), 16'(w[8:0]), "k9");
          5: cmp(16'(o_dec.k7), 16'(w[6:0]), "k7");
          6: cmp(16'(o_dec.k5), 16'(w[4:0]), "k5");
          7: begin
            cmp(16'(o_dec.k6), 16'(w[5:0]), "k6");
            cmp(16'(o_dec.ptr_n), 16'(w[6]), "ofs ptr");
          end
          8: begin
            cmp(16'(o_dec.ptr_n), 16'(w[2]), "step ptr");
            cmp(16'(o_dec.ptr_mode), 16'(w[1:0]), "mode");
          end
          default: ;
        endcase
        if (kd < 2) cmp(16'(o_dec.faddr), 16'(w[6:0]), "faddr");
        n++;
        {clk_n, ex_n, in_n, np_n, rd_n, wf_n, wa_n} = '0;
      end
      if (o_rd_file) cmp(16'(o_phase), 16'h0001, "rd phase");
      if (o_wr_file) cmp(16'(rd_n), 16'h0001, "rmw order");
      if (o_wr_file | o_wr_acc) cmp(16'(o_phase), 16'h0003, "wr ph");
      clk_n++;
      ex_n += o_exec;
      in_n += o_ind_cyc;
      np_n += o_nop_cyc;
      rd_n += o_rd_file;
      wf_n += o_wr_file;
      wa_n += o_wr_acc;
      last_cyc = o_cycles;
    end
  end

  // ==========================================================
  // clock, stimulus and watchdog
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #200us;
    error_cnt++;
    print_verdict();
  end

  initial begin
    error_cnt = 0;
    checks    = 0;
    seed      = 38250;
    n         = 0;
    i_rst_n   = 1'b0;
    put(0, 1, 14'h1801, 1'b1, 2'h2);
    put(1, 0, 14'h0B80, 1'b1, 2'h1);
    put(2, 3, 14'h2FFF, 1'b1, 2'h3);
    put(3, 10, 14'h0100, 1'b0, 2'h0);
    put(4, 10, 14'h0103, 1'b1, 2'h3);
    put(5, 0, 14'h07FF, 1'b0, 2'h3);
    put(6, 1, 14'h1C00, 1'b0, 2'h1);
    put(7, 9, 14'h000B, 1'b0, 2'h0);
    for (int i = 8; i < 160; i++) gen(i);
    for (int i = 160; i < 256; i++) put(i, 9, 14'h0000, 1'b0, 2'h0);
    repeat (4) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (int t = 0; t < 5000 && n <= 160; t++) @(negedge i_sys_clk);
    if (n <= 160) error_cnt++;
    print_verdict();
  end
endmodule // tb_eight_bit_core_instr_decode
